/* File: core/pmm_pkg.sv */
// Constants and types shared by the power-managed mode controller
package pmm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int CPU_START_DELAY_NS = 1000;
  localparam int CSD_CYC_RAW = (CPU_START_DELAY_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int CPU_START_DELAY_CYC = (CSD_CYC_RAW < 1) ? 1 : CSD_CYC_RAW;
  localparam int DELAY_CNT_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] MODE_STAT_ADDR = 4'h1;
  localparam logic [3:0] OSC_CFG_ADDR = 4'h2;

  // Oscillator control register fields
  localparam int IDLE_BIT_POS = 7;
  localparam int SRC_SEL_LSB = 0;
  localparam int SRC_SEL_W = 2;
  localparam logic IDLE_BIT_RST = 1'h0;
  localparam logic [1:0] SRC_SEL_RST = 2'h0;

  // Mode status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_CPU_POS = 3;
  localparam int STAT_PERIPH_POS = 4;
  localparam int STAT_SRC_LSB = 5;
  localparam int STAT_PEND_POS = 7;

  // Primary oscillator configuration width
  localparam int CFG_W = 4;

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 3;
  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SLEEP,
    PRIMARY_RUN_MODE,
    SECONDARY_RUN_MODE,
    INTERNAL_RUN_MODE,
    PRIMARY_IDLE_MODE,
    SECONDARY_IDLE_MODE,
    INTERNAL_IDLE_MODE
  } pmm_mode_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_CPU_DELAY,
    ST_SLEEP,
    ST_WAKE_WAIT
  } pmm_state_t;

endpackage

/* File: core/pmm_clk_if.sv */
// Interface between the mode controller and the clock source switch
`timescale 1ns/1ps
interface pmm_clk_if;
  logic [1:0] target_src; // Source requested by the controller
  logic [2:0] src_ready;  // Synchronised running flags
  logic [1:0] active_src; // Source currently feeding the enables
  logic tick;             // One pulse per active source rising edge
  logic switching;        // Switch pending

  modport ctrl (
    output target_src,
    input src_ready,
    input active_src,
    input tick,
    input switching
  );

  modport sw (
    input target_src,
    output src_ready,
    output active_src,
    output tick,
    output switching
  );
endinterface

/* File: core/pmm_clk_switch.sv */
// Glitch-free clock source selector with oscillator synchronisers
`timescale 1ns/1ps
module pmm_clk_switch (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] osc_i,
  input wire logic [2:0] ready_i,
  pmm_clk_if.sw link
);

  logic [2:0] lvl_s1_q;
  logic [2:0] lvl_s2_q;
  logic [2:0] lvl_s3_q;
  logic [2:0] rdy_s1_q;
  logic [2:0] rdy_s2_q;
  logic [1:0] active_q;
  logic safe_point;

  // ----------------------------------------------------------------
  // Per-source synchronisers and edge history
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pmm_pkg::NUM_SRC; g++) begin : g_src
      // Two flops per pin, third flop only for edge detection
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          lvl_s1_q[g] <= 1'h0;
          lvl_s2_q[g] <= 1'h0;
          lvl_s3_q[g] <= 1'h0;
          rdy_s1_q[g] <= 1'h0;
          rdy_s2_q[g] <= 1'h0;
        end else begin
          lvl_s1_q[g] <= osc_i[g];
          lvl_s2_q[g] <= lvl_s1_q[g];
          lvl_s3_q[g] <= lvl_s2_q[g];
          rdy_s1_q[g] <= ready_i[g];
          rdy_s2_q[g] <= rdy_s1_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source switch
  // ----------------------------------------------------------------
  // Both sources low: old period finished, new one starts whole
  assign safe_point = !lvl_s2_q[active_q] && !lvl_s2_q[link.target_src];

  // Move only when target runs and both phases are low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_q <= pmm_pkg::SRC_PRI;
    end else if (link.target_src != active_q && rdy_s2_q[link.target_src] && safe_point) begin
      active_q <= link.target_src;
    end
  end

  // Tick only on a full rising edge of the active source
  assign link.tick = lvl_s2_q[active_q] && !lvl_s3_q[active_q];
  assign link.active_src = active_q;
  assign link.src_ready = rdy_s2_q;
  assign link.switching = (link.target_src != active_q);

endmodule

/* File: core/pmm_core.sv */
// Power-managed mode controller: run, idle and sleep clocking
//
// Functional notes
// - CPU clocking follows the idle-on-sleep bit and the source follows the select field.
// - The select field picks primary, Timer1 secondary or internal oscillator block.
// - Changing the select field switches to the new source at once when it runs; the selector also waits until both sources are low.
// - Idle or Sleep is entered only when the sleep instruction executes.
// - The idle-on-sleep bit is sampled when the sleep instruction executes.
// - Sleep stops CPU and peripheral clocks and disables every oscillator.
// - Select 00 in run clocks CPU and peripherals from the primary source.
// - Select 01 in run clocks CPU and peripherals from the Timer1 oscillator.
// - Select 1x in run clocks CPU and peripherals from the internal oscillator block.
// - Idle stops the CPU clock and keeps peripherals on the selected source.
// - Exactly seven modes exist: three run, three idle and sleep.
// - Wake-up leaves the idle-on-sleep bit and the select field unchanged.
// - After an idle wake the CPU waits the start delay, then runs on the idle source.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module pmm_core (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SLEEP_EXEC_I,
  input wire logic WAKE_I,
  input wire logic [3:0] PRIMARY_OSC_CONFIG_I,
  input wire logic [2:0] OSC_I,
  input wire logic [2:0] OSC_READY_I,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic CPU_HOLD_O,
  output logic [2:0] OSC_EN_O,
  output logic [2:0] MODE_O,
  output logic [1:0] ACTIVE_SRC_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmm_clk_if link ();

  logic idle_on_sleep_bit_q;
  logic [1:0] clock_source_select_q;
  pmm_pkg::pmm_state_t state_q;
  logic [7:0] delay_cnt_q;
  pmm_pkg::pmm_mode_t mode_q;
  pmm_pkg::pmm_mode_t mode_d;
  logic cpu_en_q;
  logic periph_en_q;
  logic cpu_hold_q;
  logic [2:0] osc_en_q;
  logic [2:0] osc_en_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] cfg_s1_q;
  logic [3:0] cfg_s2_q;
  logic [1:0] target_src;
  logic cpu_on;
  logic periph_on;
  logic ctrl_wr;
  logic [7:0] stat_word;

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  // 00 primary, 01 Timer1, 1x internal block
  always_comb begin
    if (clock_source_select_q[1]) begin
      target_src = pmm_pkg::SRC_INT;
    end else if (clock_source_select_q[0]) begin
      target_src = pmm_pkg::SRC_SEC;
    end else begin
      target_src = pmm_pkg::SRC_PRI;
    end
  end

  assign link.target_src = target_src;

  // ----------------------------------------------------------------
  // Clock source switch
  // ----------------------------------------------------------------
  // Selector picks the active source without short pulses
  pmm_clk_switch u_switch (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .osc_i(OSC_I),
    .ready_i(OSC_READY_I),
    .link(link)
  );

  // ----------------------------------------------------------------
  // Oscillator control register
  // ----------------------------------------------------------------
  assign ctrl_wr = WR_I && (ADDR_I == pmm_pkg::OSC_CTRL_ADDR);

  // Idle bit changes only by a software write, never by a wake
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      idle_on_sleep_bit_q <= pmm_pkg::IDLE_BIT_RST;
    end else if (ctrl_wr) begin
      idle_on_sleep_bit_q <= WDATA_I[pmm_pkg::IDLE_BIT_POS];
    end
  end

  // Select field likewise; a new value starts a source switch
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      clock_source_select_q <= pmm_pkg::SRC_SEL_RST;
    end else if (ctrl_wr) begin
      clock_source_select_q <= WDATA_I[pmm_pkg::SRC_SEL_LSB +: pmm_pkg::SRC_SEL_W];
    end
  end

  // ----------------------------------------------------------------
  // Primary oscillator configuration strap
  // ----------------------------------------------------------------
  // Strap pins pass two flops before being read back
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cfg_s1_q <= 4'h0;
      cfg_s2_q <= 4'h0;
    end else begin
      cfg_s1_q <= PRIMARY_OSC_CONFIG_I;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  // Sleep instruction samples the idle bit; wakes return to run
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= pmm_pkg::ST_RUN;
      delay_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        pmm_pkg::ST_RUN: begin
          // Low-power entry only on the sleep instruction
          if (SLEEP_EXEC_I) begin
            if (idle_on_sleep_bit_q) begin
              state_q <= pmm_pkg::ST_IDLE;
            end else begin
              state_q <= pmm_pkg::ST_SLEEP;
            end
          end
        end
        pmm_pkg::ST_IDLE: begin
          // Wake starts the CPU start delay
          if (WAKE_I) begin
            state_q <= pmm_pkg::ST_CPU_DELAY;
            delay_cnt_q <= 8'(pmm_pkg::CPU_START_DELAY_CYC - 1);
          end
        end
        pmm_pkg::ST_CPU_DELAY: begin
          // CPU held for the start delay, then runs on the idle source
          if (delay_cnt_q == 8'h00) begin
            state_q <= pmm_pkg::ST_RUN;
          end else begin
            delay_cnt_q <= delay_cnt_q - 8'h01;
          end
        end
        pmm_pkg::ST_SLEEP: begin
          if (WAKE_I) begin
            state_q <= pmm_pkg::ST_WAKE_WAIT;
          end
        end
        pmm_pkg::ST_WAKE_WAIT: begin
          // No clocks until the selected source runs again
          if (!link.switching && link.src_ready[target_src]) begin
            state_q <= pmm_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= pmm_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock gating
  // ----------------------------------------------------------------
  // CPU only in run; peripherals in run, idle and the start delay
  assign cpu_on = (state_q == pmm_pkg::ST_RUN);
  assign periph_on = (state_q == pmm_pkg::ST_RUN) ||
                     (state_q == pmm_pkg::ST_IDLE) ||
                     (state_q == pmm_pkg::ST_CPU_DELAY);

  // Whole-period CPU pulses from the active source
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cpu_en_q <= 1'h0;
    end else begin
      cpu_en_q <= link.tick && cpu_on;
    end
  end

  // Peripheral pulses, also in idle and the start delay
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      periph_en_q <= 1'h0;
    end else begin
      periph_en_q <= link.tick && periph_on;
    end
  end

  // CPU hold flag outside run
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cpu_hold_q <= 1'h0;
    end else begin
      cpu_hold_q <= !cpu_on;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  // Sleep stops all; wake wait runs the target only; otherwise target and active source run
  always_comb begin
    osc_en_d = 3'h0;
    case (state_q)
      pmm_pkg::ST_SLEEP: begin
        osc_en_d = 3'h0;
      end
      pmm_pkg::ST_WAKE_WAIT: begin
        osc_en_d[target_src] = 1'h1;
      end
      default: begin
        osc_en_d[target_src] = 1'h1;
        osc_en_d[link.active_src] = 1'h1;
      end
    endcase
  end

  // Reset keeps only the primary oscillator running
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      osc_en_q <= 3'h1;
    end else begin
      osc_en_q <= osc_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode report
  // ----------------------------------------------------------------
  // Seven modes from sequencer state and active source
  always_comb begin
    mode_d = pmm_pkg::MODE_SLEEP;
    case (state_q)
      pmm_pkg::ST_RUN: begin
        case (link.active_src)
          pmm_pkg::SRC_SEC: mode_d = pmm_pkg::SECONDARY_RUN_MODE;
          pmm_pkg::SRC_INT: mode_d = pmm_pkg::INTERNAL_RUN_MODE;
          default: mode_d = pmm_pkg::PRIMARY_RUN_MODE;
        endcase
      end
      pmm_pkg::ST_IDLE, pmm_pkg::ST_CPU_DELAY: begin
        case (link.active_src)
          pmm_pkg::SRC_SEC: mode_d = pmm_pkg::SECONDARY_IDLE_MODE;
          pmm_pkg::SRC_INT: mode_d = pmm_pkg::INTERNAL_IDLE_MODE;
          default: mode_d = pmm_pkg::PRIMARY_IDLE_MODE;
        endcase
      end
      default: begin
        mode_d = pmm_pkg::MODE_SLEEP;
      end
    endcase
  end

  // Registered mode for the pin and the status word
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_q <= pmm_pkg::PRIMARY_RUN_MODE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Mode, clocking, active source and pending switch in one byte
  always_comb begin
    stat_word = 8'h00;
    stat_word[pmm_pkg::STAT_MODE_LSB +: 3] = mode_q;
    stat_word[pmm_pkg::STAT_CPU_POS] = cpu_on;
    stat_word[pmm_pkg::STAT_PERIPH_POS] = periph_on;
    stat_word[pmm_pkg::STAT_SRC_LSB +: 2] = link.active_src;
    stat_word[pmm_pkg::STAT_PEND_POS] = link.switching;
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_d = 8'h00;
    case (ADDR_I)
      pmm_pkg::OSC_CTRL_ADDR: begin
        rdata_d[pmm_pkg::IDLE_BIT_POS] = idle_on_sleep_bit_q;
        rdata_d[pmm_pkg::SRC_SEL_LSB +: pmm_pkg::SRC_SEL_W] = clock_source_select_q;
      end
      pmm_pkg::MODE_STAT_ADDR: begin
        rdata_d = stat_word;
      end
      pmm_pkg::OSC_CFG_ADDR: begin
        rdata_d[pmm_pkg::CFG_W - 1:0] = cfg_s2_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA_O = rdata_q;
  assign CPU_CLK_EN_O = cpu_en_q;
  assign PERIPH_CLK_EN_O = periph_en_q;
  assign CPU_HOLD_O = cpu_hold_q;
  assign OSC_EN_O = osc_en_q;
  assign MODE_O = mode_q;
  assign ACTIVE_SRC_O = link.active_src; // Flop inside the selector

endmodule

/* File: verif/pmm_core_checker.sv */
// Concurrent checks on the ports of the power-managed mode controller
`timescale 1ns/1ps
module pmm_core_checker (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic SLEEP_EXEC_I,
  input wire logic WAKE_I,
  input wire logic [3:0] PRIMARY_OSC_CONFIG_I,
  input wire logic [2:0] OSC_I,
  input wire logic [2:0] OSC_READY_I,
  input wire logic CPU_CLK_EN_O,
  input wire logic PERIPH_CLK_EN_O,
  input wire logic CPU_HOLD_O,
  input wire logic [2:0] OSC_EN_O,
  input wire logic [2:0] MODE_O,
  input wire logic [1:0] ACTIVE_SRC_O
);
  int dly_q;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  // ----------------------------------------------------------------
  // Start delay counter
  // ----------------------------------------------------------------
  // Cycles from an idle wake until the CPU runs again
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dly_q <= 0;
    end else if (!CPU_HOLD_O) begin
      dly_q <= 0;
    end else if (dly_q != 0 || (WAKE_I && MODE_O >= 3'h4)) begin
      dly_q <= dly_q + 1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_read_window:
    assert property (RDATA_O != 8'h00 |-> $past(RD_I))
    else $error("read data outside its cycle");
  chk_sleep_dark:
    assert property (MODE_O == 3'h0 && $past(MODE_O) == 3'h0
      |-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O && CPU_HOLD_O)
    else $error("clock enable seen in sleep");
  chk_idle_cpu_off:
    assert property (MODE_O inside {3'h4, 3'h5, 3'h6} |-> !CPU_CLK_EN_O)
    else $error("cpu clocked in idle");
  chk_run_both_clk:
    assert property (!CPU_HOLD_O && !$past(CPU_HOLD_O) && !$past(SLEEP_EXEC_I)
      && !$past(SLEEP_EXEC_I, 2) && MODE_O inside {3'h1, 3'h2, 3'h3}
      |-> CPU_CLK_EN_O == PERIPH_CLK_EN_O)
    else $error("run mode clocks cpu and peripherals apart");
  chk_mode_source:
    assert property ($stable(ACTIVE_SRC_O) && MODE_O != 3'h0
      |-> ACTIVE_SRC_O == 2'((MODE_O - 3'h1) % 3'h3))
    else $error("mode and active source disagree");
  chk_sleep_entry:
    assert property (SLEEP_EXEC_I && !CPU_HOLD_O && MODE_O inside {3'h1, 3'h2, 3'h3}
      |-> ##2 MODE_O inside {3'h0, 3'h4, 3'h5, 3'h6})
    else $error("sleep instruction did not lower the mode");
  chk_hold_cause:
    assert property ($rose(CPU_HOLD_O)
      |-> $past(SLEEP_EXEC_I) || $past(SLEEP_EXEC_I, 2) || $past(SLEEP_EXEC_I, 3))
    else $error("cpu stopped without a sleep instruction");
  chk_wake_delay:
    assert property ($fell(CPU_HOLD_O) && dly_q != 0
      |-> dly_q >= pmm_pkg::CPU_START_DELAY_CYC && dly_q <= pmm_pkg::CPU_START_DELAY_CYC + 4)
    else $error("cpu start delay length wrong");
  chk_wake_run:
    assert property ($fell(CPU_HOLD_O) && dly_q != 0 |-> ##[0:2] MODE_O inside {3'h1, 3'h2, 3'h3})
    else $error("idle wake did not return to run");
  chk_pulse_single:
    assert property (CPU_CLK_EN_O || PERIPH_CLK_EN_O |=> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
    else $error("clock enable longer than one cycle");
endmodule

/* File: verif/pmm_core_bench.sv */
// Self-checking bench for the power-managed mode controller
`timescale 1ns/1ps
module pmm_core_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slp = 1'b0;
  logic wake = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [2:0] osc = 3'h0;
  logic [2:0] rdy = 3'h0;
  logic [7:0] rdata;
  logic cpu_en;
  logic per_en;
  logic hold;
  logic [2:0] osc_en;
  logic [2:0] mode;
  logic [1:0] src_o;
  logic [7:0] exp_q [$];
  logic rd_d = 1'b0;
  logic [3:0] div_q = 4'h0;
  logic [2:0] allow_q = 3'h7;
  logic [31:0] rng = 32'hF3325080;
  logic [1:0] sels [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0] sel;
  logic [1:0] src;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  int c;
  int p;
  int i;

  pmm_core dut (
    .CLOCK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SLEEP_EXEC_I(slp), .WAKE_I(wake), .PRIMARY_OSC_CONFIG_I(cfg),
    .OSC_I(osc), .OSC_READY_I(rdy), .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(per_en),
    .CPU_HOLD_O(hold), .OSC_EN_O(osc_en), .MODE_O(mode), .ACTIVE_SRC_O(src_o)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task strobe(input bit w);
    @(posedge clk);
    if (w) wake <= 1'b1;
    else slp <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    slp <= 1'b0;
  endtask

  task wait_low;
    n = 0;
    while (hold !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
  endtask

  task count;
    c = 0;
    p = 0;
    repeat (48) begin
      tick(1);
      c += int'(cpu_en === 1'b1);
      p += int'(per_en === 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, oscillators, timeout and read watcher
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Oscillators run only while enabled and report ready when allowed
  always @(posedge clk) begin
    div_q <= div_q + 4'h1;
    osc <= {div_q[2], div_q[3], div_q[1]} & osc_en;
    rdy <= osc_en & allow_q;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // Compares read data with the oldest noted value
  always @(posedge clk) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_d <= rd;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rng = xs(rng);
    cfg <= rng[3:0];
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    tick(4);
    rdc(4'h0, 8'h00);
    wrt(4'h2, 8'hFF);
    rdc(4'h2, {4'h0, cfg});
    rdc(4'h9, 8'h00);
    for (i = 0; i < 4; i++) begin
      sel = sels[i];
      src = sel[1] ? 2'h2 : sel;
      rng = xs(rng);
      wrt(4'h0, {1'b0, rng[6:2], sel});
      rdc(4'h0, {6'h0, sel});
      n = 0;
      while (src_o !== src && n < 300) begin
        tick(1);
        n++;
      end
      chk({6'h0, src_o}, {6'h0, src});
      tick(2);
      chk({5'h0, mode}, {6'h0, src} + 8'h01);
      chk({5'h0, osc_en}, 8'h01 << src);
      rdc(4'h1, {1'b0, src, 2'h3, 1'b0, src + 2'h1});
      count();
      chk({7'h0, c > 0 && c == p}, 8'h01);
      strobe(1'b1);
      tick(3);
      chk({5'h0, mode}, {6'h0, src} + 8'h01);
      wrt(4'h0, {1'b1, rng[6:2], sel});
      strobe(1'b0);
      tick(3);
      chk({5'h0, mode}, {6'h0, src} + 8'h04);
      count();
      chk({7'h0, c == 0 && p > 0 && hold === 1'b1}, 8'h01);
      rdc(4'h1, {1'b0, src, 2'h2, 1'b1, src});
      strobe(1'b1);
      wait_low();
      chk({7'h0, n >= pmm_pkg::CPU_START_DELAY_CYC && n <= pmm_pkg::CPU_START_DELAY_CYC + 4},
        8'h01);
      tick(2);
      chk({5'h0, mode}, {6'h0, src} + 8'h01);
      rdc(4'h0, {1'b1, 5'h0, sel});
      strobe(1'b0);
      tick(3);
      chk({5'h0, mode}, {6'h0, src} + 8'h04);
      strobe(1'b1);
      wait_low();
      wrt(4'h0, {1'b0, rng[6:2], sel});
      strobe(1'b0);
      tick(3);
      chk({5'h0, mode}, 8'h00);
      chk({5'h0, osc_en}, 8'h00);
      @(posedge clk) allow_q[src] <= 1'b0;
      strobe(1'b1);
      tick(12);
      chk({4'h0, hold, mode}, 8'h08);
      @(posedge clk) allow_q <= 3'h7;
      wait_low();
      tick(2);
      chk({5'h0, mode}, {6'h0, src} + 8'h01);
      rdc(4'h0, {6'h0, sel});
    end
    @(posedge clk) nrst <= 1'b0;
    tick(3);
    chk({5'h0, mode}, 8'h01);
    @(posedge clk) nrst <= 1'b1;
    tick(4);
    rdc(4'h0, 8'h00);
    tick(3);
    results();
  end
endmodule

bind pmm_core pmm_core_checker chk_i (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .SLEEP_EXEC_I(SLEEP_EXEC_I), .WAKE_I(WAKE_I),
  .PRIMARY_OSC_CONFIG_I(PRIMARY_OSC_CONFIG_I), .OSC_I(OSC_I), .OSC_READY_I(OSC_READY_I),
  .CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .CPU_HOLD_O(CPU_HOLD_O),
  .OSC_EN_O(OSC_EN_O), .MODE_O(MODE_O), .ACTIVE_SRC_O(ACTIVE_SRC_O)
);
